/* hdl/adcbc_regs.vh */
/*
 * Register offsets, field positions, reset values and timing constants of the
 * converter bus and mode control block.
 * Assumes a 24-bit APB byte address with one 32-bit word per register.
 */
`ifndef ADCBC_REGS_VH
`define ADCBC_REGS_VH

// ----------------------------------------------------------------
// module placement
// ----------------------------------------------------------------
`define ADCBC_BASE_ADDR 24'hFFF700
`define ADCBC_REGION_MSB 23
`define ADCBC_REGION_LSB 7

// ----------------------------------------------------------------
// word offsets inside the 32-word region
// ----------------------------------------------------------------
`define ADCBC_OFF_MCR 7'h00
`define ADCBC_OFF_TST 7'h04
`define ADCBC_OFF_RSV0 7'h08
`define ADCBC_OFF_PORT 7'h0C
`define ADCBC_OFF_CTLA 7'h10
`define ADCBC_OFF_CTLB 7'h14
`define ADCBC_OFF_STAT 7'h18
`define ADCBC_OFF_RSV1 7'h1C
`define ADCBC_OFF_RJU 7'h20
`define ADCBC_OFF_LJS 7'h40
`define ADCBC_OFF_LJU 7'h60

// ----------------------------------------------------------------
// module configuration register
// ----------------------------------------------------------------
`define ADCBC_MCR_STOP 7
`define ADCBC_MCR_FRZ_HI 5
`define ADCBC_MCR_FRZ_LO 4
`define ADCBC_MCR_RST 8'h80
`define ADCBC_FRZ_IGNORE 2'h0
`define ADCBC_FRZ_RSVD 2'h1
`define ADCBC_FRZ_FINISH 2'h2
`define ADCBC_FRZ_NOW 2'h3

// ----------------------------------------------------------------
// conversion control register a
// ----------------------------------------------------------------
`define ADCBC_CTLA_RES10 7
`define ADCBC_CTLA_STS_HI 6
`define ADCBC_CTLA_STS_LO 5
`define ADCBC_CTLA_PRS_HI 4
`define ADCBC_CTLA_PRS_LO 0
`define ADCBC_CTLA_RST 8'h03

// ----------------------------------------------------------------
// conversion control register b
// ----------------------------------------------------------------
`define ADCBC_CTLB_SCAN 6
`define ADCBC_CTLB_MULT 5
`define ADCBC_CTLB_S8CM 4
`define ADCBC_CTLB_CH_HI 3
`define ADCBC_CTLB_CH_LO 0
`define ADCBC_CTLB_RST 7'h00

// ----------------------------------------------------------------
// status register
// ----------------------------------------------------------------
`define ADCBC_STAT_SCF 15
`define ADCBC_STAT_CCTR_HI 10
`define ADCBC_STAT_CCTR_LO 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCBC_SAMPLE_FIXED 5'h04
`define ADCBC_TST_RST 8'h00

`endif

/* hdl/adcbc_sync.v */
/*
 * Two-flop synchroniser, one instance per bit through a generate loop.
 * Assumes inputs come from pins outside the clock domain.
 */
`timescale 1ns/1ps
module adcbc_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk,
    input wire rstN,
    // data
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            always @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= asyncIn[i];
                    sync_r <= meta_r;
                end
            end
            assign syncOut[i] = sync_r;
        end
    endgenerate
endmodule // adcbc_sync

/* hdl/adcbc_seq.v */
/*
 * Conversion sequencer: prescaler, sample phase, successive approximation and
 * sequence stepping across channels, with abort, stop and freeze holds.
 * Assumes the comparator input is already synchronised to clk.
 */
`timescale 1ns/1ps
`include "adcbc_regs.vh"
module adcbc_seq (
    // clock and reset
    input wire clk,
    input wire rstN,
    // control
    input wire abort,
    input wire start,
    input wire hold,
    input wire holdAtEnd,
    input wire res10,
    input wire [1:0] sts,
    input wire [4:0] prs,
    input wire scan,
    input wire mult,
    input wire s8cm,
    input wire [3:0] chan,
    input wire compIn,
    // status and results
    output reg busy,
    output reg [2:0] convIdx,
    output reg [3:0] curChan,
    output reg [9:0] trial,
    output reg resWr,
    output reg seqDone
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [2:0] state_r;
    reg [5:0] pre_r;
    reg half_r;
    reg [4:0] step_r;
    reg [3:0] bit_r;
    wire tick = (pre_r == 6'h00) && half_r;
    wire [4:0] sampleLen = `ADCBC_SAMPLE_FIXED + (5'h02 << sts);
    wire [2:0] lastIdx = s8cm ? 3'h7 : 3'h3;
    wire [3:0] nextChan = mult ? {chan[3] , (s8cm ? 3'h0 : {chan[2], 2'h0})} : chan;
    // freeze in finish mode only takes hold between conversions
    wire frozen = hold || (holdAtEnd && state_r == ST_SAMPLE && step_r == 5'h00);

    always @* begin
        curChan = mult ? (nextChan | {1'b0, convIdx}) : chan;
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r <= ST_IDLE;
            pre_r <= 6'h00;
            half_r <= 1'b0;
            step_r <= 5'h00;
            bit_r <= 4'h0;
            busy <= 1'b0;
            convIdx <= 3'h0;
            trial <= 10'h000;
            resWr <= 1'b0;
            seqDone <= 1'b0;
        end else begin
            resWr <= 1'b0;
            seqDone <= 1'b0;
            if (abort) begin
                state_r <= start ? ST_SAMPLE : ST_IDLE;
                busy <= start;
                pre_r <= 6'h00;
                half_r <= 1'b0;
                step_r <= 5'h00;
                convIdx <= 3'h0;
                trial <= 10'h000;
            end else if (!frozen && state_r != ST_IDLE) begin
                // prescaler: modulus stage then divide by two
                if (pre_r == 6'h00) begin
                    pre_r <= {1'b0, prs};
                    half_r <= ~half_r;
                end else begin
                    pre_r <= pre_r - 6'h01;
                end
                if (tick) begin
                    case (state_r)
                        ST_SAMPLE: begin
                            if (step_r == sampleLen - 5'h01) begin
                                step_r <= 5'h00;
                                state_r <= ST_CONV;
                                // 8-bit results sit in the upper trial bits, so both start at the msb
                                bit_r <= 4'h9;
                                trial <= 10'h200;
                            end else begin
                                step_r <= step_r + 5'h01;
                            end
                        end
                        ST_CONV: begin
                            if (!compIn) begin
                                trial[bit_r] <= 1'b0;
                            end
                            if (bit_r == (res10 ? 4'h0 : 4'h2)) begin
                                resWr <= 1'b1;
                                state_r <= ST_SAMPLE;
                                if (convIdx == lastIdx || !mult && !s8cm && !scan && convIdx == 3'h0) begin
                                    seqDone <= 1'b1;
                                    convIdx <= 3'h0;
                                    if (!scan) begin
                                        state_r <= ST_IDLE;
                                        busy <= 1'b0;
                                    end
                                end else begin
                                    convIdx <= convIdx + 3'h1;
                                end
                            end else begin
                                bit_r <= bit_r - 4'h1;
                                trial[bit_r - 4'h1] <= 1'b1;
                            end
                        end
                        default: state_r <= ST_IDLE;
                    endcase
                end
            end
        end
    end
endmodule // adcbc_seq

/* hdl/adcbc_top.v */
/*
 * Converter bus and mode control: APB slave over a 32-word register region,
 * digital read of the analog pins, result routing in three formats, low-power
 * stop and debug freeze handling around the conversion sequencer.
 * Assumes an APB master on clk, asynchronous pin inputs and an analog front
 * end that returns one comparator decision per approximation step.
 */
// Functional notes
// [R1] The block decodes 32 words: five control/status, one port, 24 results and two reserved.
// [R2] The region base follows the module map bit and sits at FFF700 when that bit is set.
// [R3] Configuration, test and port registers form one group, conversion and result registers another.
// [R4] Buffered registers update at once, and a write to any conversion control register aborts a conversion.
// [R5] The block acts only as a slave, answers every access to its region and synchronises converter signals.
// [R6] Results are routed onto the bus in right unsigned, left signed and left unsigned formats.
// [R7] The eight analog pins read as an input-only 8-bit port with no direction register.
// [R8] The converter has eight operating modes and 8-bit or 10-bit resolution.
// [R9] While stop is set the converter core idles yet every register stays accessible.
// [R10] Setting stop during a conversion aborts it.
// [R11] Stop is set by reset and software clears it and waits a recovery time before converting.
// [R12] The freeze field picks ignore, finish then freeze, or freeze at once.
// [R13] While frozen all converter activity stops and control and status stay valid; converterClkOn stays on when frozen in finish mode.
// [R14] When freeze negates the interrupted sequence continues at its next step.
// [R15] Writing control register a aborts the sequence and halts until register b is written.
// [R16] Writing control register b aborts the sequence and starts a new one with the new settings; none starts while stop is set or pwdata bit 31 is set.
// [R17] The reserved freeze value 01 behaves like 00 and ignores freeze.
`timescale 1ns/1ps
`include "adcbc_regs.vh"
module adcbc_top (
    // clock and reset
    input wire clk,
    input wire nrst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [23:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // system
    input wire moduleMapBit,
    input wire freezeIn,
    // analog side
    input wire [7:0] analogPortPins,
    input wire compIn,
    output reg [3:0] muxSel,
    output reg [9:0] dacTrial,
    output reg converterClkOn
);
    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    reg rstMeta_r;
    reg rstN;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN <= rstMeta_r;
        end
    end

    wire [9:0] pinSync;
    adcbc_sync #(.WIDTH(10)) uSync ( // R5 R7
        .clk(clk),
        .rstN(rstN),
        .asyncIn({freezeIn, compIn, analogPortPins}),
        .syncOut(pinSync)
    );
    wire freezeS = pinSync[9];
    wire compS = pinSync[8];
    wire [7:0] portS = pinSync[7:0];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] mcr_r;
    reg [7:0] tst_r;
    reg [7:0] ctla_r;
    reg [6:0] ctlb_r;
    reg [7:0] ccf_r;
    reg [7:0] ccf_nxt;
    reg scf_r;
    reg scf_nxt;
    reg [9:0] res_r [0:7];
    reg [7:0] resIs10_r;
    // convIdx has already stepped on when resWr shows, so keep the index it had
    reg [2:0] resIdx_r;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire [23:0] baseConst = `ADCBC_BASE_ADDR;
    wire [23:0] baseAddr = {moduleMapBit, baseConst[22:0]}; // R2
    wire inRegion = paddr[`ADCBC_REGION_MSB:`ADCBC_REGION_LSB] ==
        baseAddr[`ADCBC_REGION_MSB:`ADCBC_REGION_LSB]; // R1
    wire [6:0] off = {paddr[6:2], 2'b00};
    wire wrStb = psel && penable && pready && pwrite && inRegion;
    wire wrMcr = wrStb && off == `ADCBC_OFF_MCR;
    wire wrTst = wrStb && off == `ADCBC_OFF_TST;
    wire wrCtla = wrStb && off == `ADCBC_OFF_CTLA;
    wire wrCtlb = wrStb && off == `ADCBC_OFF_CTLB;

    wire stopBit = mcr_r[`ADCBC_MCR_STOP];
    wire [1:0] frzField = mcr_r[`ADCBC_MCR_FRZ_HI:`ADCBC_MCR_FRZ_LO];
    // stop rising by a write aborts; ctla/ctlb writes abort too
    wire stopSet = wrMcr && pwdata[`ADCBC_MCR_STOP] && !stopBit; // R10
    wire seqAbort = wrCtla || wrCtlb || stopSet; // R4 R15 R16
    wire seqStart = wrCtlb && !stopBit && !pwdata[`ADCBC_MCR_STOP + 24]; // R16
    wire frzNow = freezeS && frzField == `ADCBC_FRZ_NOW; // R12 R13
    wire frzEnd = freezeS && frzField == `ADCBC_FRZ_FINISH; // R12 R17

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    wire busy;
    wire [2:0] convIdx;
    wire [3:0] curChan;
    wire [9:0] trial;
    wire resWr;
    wire seqDone;
    adcbc_seq uSeq (
        .clk(clk),
        .rstN(rstN),
        .abort(seqAbort),
        .start(seqStart),
        .hold(stopBit || frzNow), // R9 R13 R14
        .holdAtEnd(frzEnd),
        .res10(ctla_r[`ADCBC_CTLA_RES10]), // R8
        .sts(ctla_r[`ADCBC_CTLA_STS_HI:`ADCBC_CTLA_STS_LO]),
        .prs(ctla_r[`ADCBC_CTLA_PRS_HI:`ADCBC_CTLA_PRS_LO]),
        .scan(ctlb_r[`ADCBC_CTLB_SCAN]), // R8
        .mult(ctlb_r[`ADCBC_CTLB_MULT]),
        .s8cm(ctlb_r[`ADCBC_CTLB_S8CM]),
        .chan(ctlb_r[`ADCBC_CTLB_CH_HI:`ADCBC_CTLB_CH_LO]),
        .compIn(compS),
        .busy(busy),
        .convIdx(convIdx),
        .curChan(curChan),
        .trial(trial),
        .resWr(resWr),
        .seqDone(seqDone)
    );

    // ----------------------------------------------------------------
    // register writes and status flags
    // ----------------------------------------------------------------
    always @* begin
        ccf_nxt = ccf_r;
        scf_nxt = scf_r;
        if (wrCtla || wrCtlb) begin
            ccf_nxt = 8'h00;
            scf_nxt = 1'b0;
        end
        // a completion in the clearing cycle must not be lost
        if (resWr) begin
            ccf_nxt[resIdx_r] = 1'b1;
        end
        if (seqDone) begin
            scf_nxt = 1'b1;
        end
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mcr_r <= `ADCBC_MCR_RST; // R11
            tst_r <= `ADCBC_TST_RST;
            ctla_r <= `ADCBC_CTLA_RST;
            ctlb_r <= `ADCBC_CTLB_RST;
            ccf_r <= 8'h00;
            scf_r <= 1'b0;
            resIs10_r <= 8'h00;
            resIdx_r <= 3'h0;
        end else begin
            resIdx_r <= convIdx;
            ccf_r <= ccf_nxt;
            scf_r <= scf_nxt;
            if (wrMcr) begin
                mcr_r <= pwdata[7:0] & 8'hB0; // R3 R4
            end
            if (wrTst) begin
                tst_r <= pwdata[7:0];
            end
            if (wrCtla) begin
                ctla_r <= pwdata[7:0];
            end
            if (wrCtlb) begin
                ctlb_r <= pwdata[6:0];
            end
            if (resWr) begin
                resIs10_r[resIdx_r] <= ctla_r[`ADCBC_CTLA_RES10];
            end
        end
    end

    // result memory has no reset; ccf tells software which words are fresh
    always @(posedge clk) begin
        if (resWr) begin
            res_r[resIdx_r] <= trial;
        end
    end

    // ----------------------------------------------------------------
    // read mux and result formats
    // ----------------------------------------------------------------
    reg [31:0] rdData;
    reg [9:0] rv;
    reg [9:0] leftV;
    always @* begin
        rv = res_r[paddr[4:2]];
        leftV = resIs10_r[paddr[4:2]] ? rv : {rv[9:2], 2'b00};
        rdData = 32'h00000000;
        case (off[6:5])
            2'h0: begin
                case (off)
                    `ADCBC_OFF_MCR: rdData = {24'h000000, mcr_r};
                    `ADCBC_OFF_TST: rdData = {24'h000000, tst_r};
                    `ADCBC_OFF_PORT: rdData = {24'h000000, portS}; // R7
                    `ADCBC_OFF_CTLA: rdData = {24'h000000, ctla_r};
                    `ADCBC_OFF_CTLB: rdData = {25'h0000000, ctlb_r};
                    `ADCBC_OFF_STAT: rdData = {16'h0000, scf_r, 4'h0, convIdx, ccf_r};
                    default: rdData = 32'h00000000;
                endcase
            end
            2'h1: rdData = resIs10_r[paddr[4:2]] ? {22'h000000, rv} : {24'h000000, rv[9:2]}; // R6
            2'h2: rdData = {16'h0000, ~leftV[9], leftV[8:0], 6'h00}; // R6
            default: rdData = {16'h0000, leftV, 6'h00}; // R6
        endcase
    end

    // ----------------------------------------------------------------
    // apb answer: one wait-free access cycle for every transfer
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            muxSel <= 4'h0;
            dacTrial <= 10'h000;
            converterClkOn <= 1'b0;
        end else begin
            pready <= psel && !penable; // R5
            pslverr <= psel && !penable && !inRegion;
            if (psel && !penable) begin
                prdata <= (inRegion && !pwrite) ? rdData : 32'h00000000;
            end
            muxSel <= curChan;
            dacTrial <= trial;
            converterClkOn <= !stopBit && !frzNow && busy; // R9 R13
        end
    end
endmodule // adcbc_top

/* bench/adcbc_afe_model.sv */
/*
 * Comparator stand-in for the analog front end.
 * Assumes every channel sees the same held input level.
 */
`timescale 1ns/1ps
module adcbc_afe_model (
    // converter side
    input wire [9:0] dacTrial,
    input wire [9:0] level,
    output logic compIn
);
    // keep the trial bit while the trial does not exceed the input
    assign compIn = (dacTrial <= level);
endmodule // adcbc_afe_model

/* bench/adcbc_top_assertions.sv */
/*
 * Port checker for the converter bus block.
 * Assumes an APB master that holds each request until pready.
 */
`timescale 1ns/1ps
`include "adcbc_regs.vh"
module adcbc_top_assertions (
    // clock and reset
    input wire clk,
    input wire nrst,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [23:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // system
    input wire moduleMapBit,
    input wire converterClkOn
);
    localparam logic [23:0] BASE = `ADCBC_BASE_ADDR;
    wire inRegion = (paddr[23] == moduleMapBit) && (paddr[22:7] == BASE[22:7]);
    wire [6:0] off = paddr[6:0];
    wire acc = pready && inRegion;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ----
    // transfer steps
    // ----
    sequence sSetup;
        psel && !penable;
    endsequence
    sequence sStopWr;
        acc && pwrite && off == `ADCBC_OFF_MCR && pwdata[`ADCBC_MCR_STOP];
    endsequence
    sequence sCtlaWr;
        acc && pwrite && off == `ADCBC_OFF_CTLA;
    endsequence

    a_ready_after_setup: assert property (sSetup |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_no_spurious_ready: assert property (!psel |=> !pready)
        else $error("pready without request");
    a_region_error: assert property (pready |-> pslverr == !inRegion)
        else $error("error flag does not match region");
    a_error_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_port_input_only: assert property (acc && !pwrite && off == `ADCBC_OFF_PORT |-> prdata[31:8] == 24'h0)
        else $error("port read has high bits");
    a_reserved_zero: assert property (acc && !pwrite && (off == `ADCBC_OFF_RSV0 || off == `ADCBC_OFF_RSV1)
        |-> prdata == 32'h0)
        else $error("reserved word not zero");
    a_stop_halts: assert property (sStopWr |-> ##[1:3] !converterClkOn)
        else $error("converter clock on after stop");
    a_ctla_halts: assert property (sCtlaWr |-> ##[1:3] !converterClkOn)
        else $error("converter clock on after control write");
endmodule // adcbc_top_assertions

bind adcbc_top adcbc_top_assertions chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .moduleMapBit(moduleMapBit), .converterClkOn(converterClkOn));

/* bench/adcbc_top_tb.sv */
/*
 * Self-checking bench for the converter bus block.
 * Assumes the comparator model as the analog side and one APB master.
 */
`timescale 1ns/1ps
`include "adcbc_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adcbc_top_tb;
    logic clk = 0;
    logic nrst = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic moduleMapBit = 1;
    logic freezeIn = 0;
    logic [23:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [7:0] analogPortPins = 0;
    wire [31:0] prdata;
    wire pready, pslverr, compIn, converterClkOn;
    wire [3:0] muxSel;
    wire [9:0] dacTrial;
    logic [31:0] rdat;
    logic rerr;
    logic [9:0] trialHeld;
    logic [23:0] base = `ADCBC_BASE_ADDR;
    int num_errors = 0;
    int num_checks = 0;
    localparam logic [9:0] LVL = 10'h2C5;
    logic [6:0] offs [5] = '{`ADCBC_OFF_MCR, `ADCBC_OFF_TST, `ADCBC_OFF_CTLA, `ADCBC_OFF_CTLB, `ADCBC_OFF_STAT};
    logic [31:0] rstv [5] = '{32'h80, 32'h0, 32'h3, 32'h0, 32'h0};
    logic [31:0] frzExp [4] = '{32'h80FF, 32'h80FF, 32'h1, 32'h0};

    always #50 clk = ~clk;

    adcbc_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .moduleMapBit(moduleMapBit), .freezeIn(freezeIn), .analogPortPins(analogPortPins),
        .compIn(compIn), .muxSel(muxSel), .dacTrial(dacTrial), .converterClkOn(converterClkOn));
    adcbc_afe_model afe (.dacTrial(dacTrial), .level(LVL), .compIn(compIn));

    // ----
    // bus tasks
    // ----
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [6:0] o, input logic [31:0] d);
        apb(1'b1, base + {17'h0, o}, d);
    endtask
    task rd(input logic [6:0] o);
        apb(1'b0, base + {17'h0, o}, 32'h0);
    endtask
    task waitDone(input int lim);
        int n;
        n = 0;
        rd(`ADCBC_OFF_STAT);
        while (rdat[15] !== 1'b1 && n < lim) begin
            rd(`ADCBC_OFF_STAT);
            n++;
        end
    endtask
    // three views of the same result word
    task chkRes(input logic [6:0] i);
        rd(`ADCBC_OFF_RJU + {i[4:0], 2'b00});
        `CHK(rdat, {22'h0, LVL});
        rd(`ADCBC_OFF_LJS + {i[4:0], 2'b00});
        `CHK(rdat, {16'h0, ~LVL[9], LVL[8:0], 6'h0});
        rd(`ADCBC_OFF_LJU + {i[4:0], 2'b00});
        `CHK(rdat, {16'h0, LVL, 6'h0});
    endtask

    // ----
    // tests
    // ----
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(offs[i]);
            `CHK(rdat, rstv[i]);
        end
        wr(`ADCBC_OFF_TST, 32'h5A);
        rd(`ADCBC_OFF_TST);
        `CHK(rdat, 32'h5A);
        wr(`ADCBC_OFF_RSV0, 32'hFF);
        rd(`ADCBC_OFF_RSV0);
        `CHK(rdat, 32'h0);
        wr(`ADCBC_OFF_RSV1, 32'hFF);
        rd(`ADCBC_OFF_RSV1);
        `CHK(rdat, 32'h0);
        apb(1'b0, base + 24'h80, 32'h0);
        `CHK(rerr, 1'b1);
        analogPortPins <= 8'hA5;
        repeat (3) @(posedge clk);
        wr(`ADCBC_OFF_PORT, 32'h0);
        rd(`ADCBC_OFF_PORT);
        `CHK(rdat, 32'hA5);
        moduleMapBit <= 0;
        base = base ^ 24'h800000;
        rd(`ADCBC_OFF_MCR);
        `CHK(rdat, 32'h80);
        apb(1'b0, `ADCBC_BASE_ADDR, 32'h0);
        `CHK(rerr, 1'b1);
        moduleMapBit <= 1;
        base = `ADCBC_BASE_ADDR;
        wr(`ADCBC_OFF_MCR, 32'h0);
        // recovery time before the first conversion
        repeat (20) @(posedge clk);
        wr(`ADCBC_OFF_CTLA, 32'h83);
        for (int m = 0; m < 8; m++) begin
            wr(`ADCBC_OFF_CTLB, (m << 4) | 3);
            waitDone(400);
            `CHK(rdat[15], 1'b1);
            chkRes(7'h0);
        end
        // 8-bit resolution keeps the upper eight bits of the level
        wr(`ADCBC_OFF_CTLA, 32'h03);
        wr(`ADCBC_OFF_CTLB, 32'h3);
        waitDone(400);
        `CHK(rdat[15], 1'b1);
        rd(`ADCBC_OFF_RJU);
        `CHK(rdat, {24'h0, LVL[9:2]});
        rd(`ADCBC_OFF_LJS);
        `CHK(rdat, {16'h0, ~LVL[9], LVL[8:2], 8'h0});
        rd(`ADCBC_OFF_LJU);
        `CHK(rdat, {16'h0, LVL[9:2], 8'h0});
        wr(`ADCBC_OFF_CTLA, 32'h83);
        wr(`ADCBC_OFF_CTLB, 32'h3);
        repeat (30) @(posedge clk);
        wr(`ADCBC_OFF_CTLA, 32'h83);
        repeat (300) @(posedge clk);
        rd(`ADCBC_OFF_STAT);
        `CHK(rdat[15], 1'b0);
        wr(`ADCBC_OFF_CTLB, 32'h3);
        repeat (30) @(posedge clk);
        wr(`ADCBC_OFF_MCR, 32'h80);
        repeat (300) @(posedge clk);
        rd(`ADCBC_OFF_STAT);
        `CHK(rdat[15], 1'b0);
        wr(`ADCBC_OFF_TST, 32'h3C);
        rd(`ADCBC_OFF_TST);
        `CHK(rdat, 32'h3C);
        // freeze lands early in the first of eight conversions
        for (int f = 0; f < 4; f++) begin
            wr(`ADCBC_OFF_MCR, f << 4);
            wr(`ADCBC_OFF_CTLB, 32'h13);
            repeat (60) @(posedge clk);
            freezeIn <= 1;
            repeat (20) @(posedge clk);
            trialHeld = dacTrial;
            repeat (1300) @(posedge clk);
            rd(`ADCBC_OFF_STAT);
            `CHK(rdat & 32'h80FF, frzExp[f]);
            if (f == 3) begin
                `CHK(dacTrial, trialHeld);
                `CHK(muxSel, 4'h3);
            end
            freezeIn <= 0;
            waitDone(500);
            `CHK(rdat & 32'h80FF, 32'h80FF);
            chkRes(7'h7);
        end
        end_of_test;
    end

    initial begin
        #4000000;
        num_errors++;
        $display("[ERR] %0t watchdog", $time);
        end_of_test;
    end
endmodule // adcbc_top_tb
